// ===== design/nvm_access_ctrl.sv
// Data nonvolatile memory access controller behind three registers.
`timescale 1ns/10ps
module nvm_access_ctrl
   import nvm_pkg::*;
#(
   parameter int DEPTH = DEPTH_LARGE,
   parameter int STORE_CYC = STORE_CYCLES
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire sfr_req_t req,
   input wire logic done_clear,
   output logic [7:0] rdata,
   output logic done_flag,
   output logic busy
);
   localparam int AW = (DEPTH == DEPTH_SMALL) ? 7 : 8;

   // Only the two array sizes have a decoder; refuse others at elaboration.
   if (DEPTH != DEPTH_SMALL && DEPTH != DEPTH_LARGE) begin : g_bad_depth
      $error("DEPTH must be 128 or 256");
   end
   // The cycle counter is sixteen bits wide.
   if (STORE_CYC < 1 || STORE_CYC > 65536) begin : g_bad_store
      $error("STORE_CYC must lie between 1 and 65536");
   end

   function automatic logic hit(input sfr_req_t r, input logic [7:0] a,
                                input logic [1:0] b);
      hit = (r.addr == a) && (r.indirect ? (r.bank == b) : (b == DATA_BANK));
   endfunction : hit

   logic [7:0] mem_q [DEPTH];
   logic [AW-1:0] loc_q;
   logic [7:0] byte_q;
   logic [3:0] ctrl_q;
   nvm_state_t state_q;
   logic [15:0] cnt_q;
   logic [AW-1:0] wloc_q;
   logic [7:0] wbyte_q;
   logic done_q;
   logic [7:0] rdata_q;

   wire loc_hit = hit(req, LOC_REG_ADDR, DATA_BANK);
   wire byte_hit = hit(req, BYTE_REG_ADDR, DATA_BANK);
   // Direct access always lands in bank 0, so only the indirect path reaches.
   wire ctrl_hit = req.indirect && hit(req, CTRL_REG_ADDR, CTRL_BANK);
   wire ctrl_wr = req.wr && ctrl_hit;
   // Triggers are honoured only if the permit was already set.
   wire store_go = ctrl_wr && req.wdata[STORE_TRIG_BIT]
      && ctrl_q[STORE_PERMIT_BIT] && state_q == ST_IDLE;
   wire fetch_go = ctrl_wr && req.wdata[FETCH_TRIG_BIT]
      && ctrl_q[FETCH_PERMIT_BIT] && state_q == ST_IDLE && !store_go;
   wire cyc_end = (state_q != ST_IDLE) && cnt_q == 16'h0000;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         cnt_q <= 16'h0000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (store_go) begin
                  state_q <= ST_STORE;
                  cnt_q <= 16'(STORE_CYC - 1);
               end else if (fetch_go) begin
                  state_q <= ST_FETCH;
                  cnt_q <= 16'(FETCH_CYCLES - 1);
               end
            end
            ST_FETCH, ST_STORE: begin
               if (cnt_q == 16'h0000)
                  state_q <= ST_IDLE;
               else
                  cnt_q <= cnt_q - 16'h0001;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Control bits; triggers mirror the running cycle and fall when it ends.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RESET[3:0];
      end else begin
         if (ctrl_wr) begin
            ctrl_q[STORE_PERMIT_BIT] <= req.wdata[STORE_PERMIT_BIT];
            ctrl_q[FETCH_PERMIT_BIT] <= req.wdata[FETCH_PERMIT_BIT];
         end
         if (store_go)
            ctrl_q[STORE_TRIG_BIT] <= 1'b1;
         else if (cyc_end && state_q == ST_STORE)
            ctrl_q[STORE_TRIG_BIT] <= 1'b0;
         if (fetch_go)
            ctrl_q[FETCH_TRIG_BIT] <= 1'b1;
         else if (cyc_end && state_q == ST_FETCH)
            ctrl_q[FETCH_TRIG_BIT] <= 1'b0;
      end
   end

   // Address and data registers; a finished read loads the byte register.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         loc_q <= LOC_RESET[AW-1:0];
         byte_q <= BYTE_RESET;
      end else begin
         if (req.wr && loc_hit)
            loc_q <= req.wdata[AW-1:0];
         if (cyc_end && state_q == ST_FETCH)
            byte_q <= mem_q[loc_q];
         else if (req.wr && byte_hit)
            byte_q <= req.wdata;
      end
   end

   // Write operands captured at start so later register writes are harmless.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wloc_q <= LOC_RESET[AW-1:0];
         wbyte_q <= BYTE_RESET;
      end else if (store_go) begin
         wloc_q <= loc_q;
         wbyte_q <= byte_q;
      end
   end

   // The array has no reset; it models nonvolatile contents.
   // Clearing the store permit mid-cycle drops the byte; done still sets.
   always_ff @(posedge mclk) begin
      if (cyc_end && state_q == ST_STORE && ctrl_q[STORE_PERMIT_BIT])
         mem_q[wloc_q] <= wbyte_q;
   end

   // Done flag: hardware set wins over a software clear in the same cycle.
   always_ff @(posedge mclk) begin
      if (!nrst)
         done_q <= 1'b0;
      else if (cyc_end && state_q == ST_STORE)
         done_q <= 1'b1;
      else if (done_clear)
         done_q <= 1'b0;
   end

   // Read data is registered; unmapped addresses return zero.
   always_ff @(posedge mclk) begin
      if (!nrst)
         rdata_q <= 8'h00;
      else if (req.rd && loc_hit)
         rdata_q <= 8'(loc_q);
      else if (req.rd && byte_hit)
         rdata_q <= byte_q;
      else if (req.rd && ctrl_hit)
         rdata_q <= {4'h0, ctrl_q} & CTRL_IMPL_MASK;
      else
         rdata_q <= 8'h00;
   end

   assign rdata = rdata_q;
   assign done_flag = done_q;
   assign busy = ctrl_q[STORE_TRIG_BIT];

   // Named steps of the two cycle kinds; the properties below build on them.
   sequence store_start;
      store_go;
   endsequence

   sequence store_finish;
      cyc_end && state_q == ST_STORE;
   endsequence

   sequence fetch_start;
      fetch_go;
   endsequence

   // The repeat count follows FETCH_CYCLES; change both together.
   sequence fetch_run;
      fetch_start ##1 ctrl_q[FETCH_TRIG_BIT] [*2];
   endsequence

   // A refused trigger starts nothing, so stray writes leave the array.
   a_store_blocked: assert property (@(posedge mclk)
      disable iff (!nrst)
      (ctrl_wr && req.wdata[STORE_TRIG_BIT] && !ctrl_q[STORE_PERMIT_BIT]
       && state_q == ST_IDLE) |=> state_q != ST_STORE)
      else $error("store started without permit");

   a_fetch_blocked: assert property (@(posedge mclk)
      disable iff (!nrst)
      (ctrl_wr && req.wdata[FETCH_TRIG_BIT] && !ctrl_q[FETCH_PERMIT_BIT]
       && state_q == ST_IDLE) |=> !ctrl_q[FETCH_TRIG_BIT])
      else $error("fetch started without permit");

   a_fetch_start: assert property (@(posedge mclk)
      disable iff (!nrst)
      fetch_start |=> ctrl_q[FETCH_TRIG_BIT] && state_q == ST_FETCH)
      else $error("fetch trigger not raised");

   a_fetch_clears: assert property (@(posedge mclk)
      disable iff (!nrst)
      fetch_run |=> !ctrl_q[FETCH_TRIG_BIT] && byte_q == $past(mem_q[loc_q]))
      else $error("fetch did not end as expected");

   a_idle_quiet: assert property (@(posedge mclk)
      disable iff (!nrst)
      state_q == ST_IDLE
      |-> !ctrl_q[STORE_TRIG_BIT] && !ctrl_q[FETCH_TRIG_BIT])
      else $error("trigger high while idle");

   a_store_trig: assert property (@(posedge mclk)
      disable iff (!nrst)
      store_start |=> ctrl_q[STORE_TRIG_BIT] && state_q == ST_STORE)
      else $error("store trigger not raised");

   a_store_held: assert property (@(posedge mclk)
      disable iff (!nrst)
      (state_q == ST_STORE && cnt_q != 16'h0000) |=> ctrl_q[STORE_TRIG_BIT])
      else $error("store trigger fell early");

   // Write cycle: operands held while it runs, then done flag and array contents.
   a_store_done: assert property (@(posedge mclk)
      disable iff (!nrst)
      store_finish |=> done_q && !ctrl_q[STORE_TRIG_BIT])
      else $error("store end did not set done");

   a_store_lands: assert property (@(posedge mclk)
      disable iff (!nrst)
      store_finish ##0 ctrl_q[STORE_PERMIT_BIT]
      |=> mem_q[wloc_q] == wbyte_q)
      else $error("stored byte missing from array");

   a_done_sticky: assert property (@(posedge mclk)
      disable iff (!nrst)
      (done_q && !done_clear) |=> done_q)
      else $error("done flag dropped by itself");

   a_done_clear: assert property (@(posedge mclk)
      disable iff (!nrst)
      (done_clear && !(cyc_end && state_q == ST_STORE)) |=> !done_q)
      else $error("done flag not cleared");

   a_latch_hold: assert property (@(posedge mclk)
      disable iff (!nrst)
      (state_q == ST_STORE && !cyc_end)
      |=> wbyte_q == $past(wbyte_q) && wloc_q == $past(wloc_q))
      else $error("store operand changed");

   // Register decode, permits and read-back.
   a_permit_store: assert property (@(posedge mclk)
      disable iff (!nrst)
      ctrl_wr
      |=> ctrl_q[STORE_PERMIT_BIT] == $past(req.wdata[STORE_PERMIT_BIT]))
      else $error("store permit not written");

   a_permit_fetch: assert property (@(posedge mclk)
      disable iff (!nrst)
      ctrl_wr
      |=> ctrl_q[FETCH_PERMIT_BIT] == $past(req.wdata[FETCH_PERMIT_BIT]))
      else $error("fetch permit not written");

   a_ctrl_upper: assert property (@(posedge mclk)
      disable iff (!nrst)
      (req.rd && ctrl_hit) |=> rdata_q[7:4] == 4'h0)
      else $error("control upper bits not zero");

   a_loc_width: assert property (@(posedge mclk)
      disable iff (!nrst)
      (DEPTH == DEPTH_SMALL && req.rd && loc_hit) |=> !rdata_q[7])
      else $error("small location bit 7 set");

   a_loc_read: assert property (@(posedge mclk)
      disable iff (!nrst)
      (req.rd && loc_hit) |=> rdata_q[AW-1:0] == $past(loc_q))
      else $error("location read mismatch");

   a_byte_read: assert property (@(posedge mclk)
      disable iff (!nrst)
      (req.rd && byte_hit) |=> rdata_q == $past(byte_q))
      else $error("byte read mismatch");

   a_ctrl_direct: assert property (@(posedge mclk)
      disable iff (!nrst)
      (req.wr && !req.indirect && req.addr == CTRL_REG_ADDR)
      |=> ctrl_q[STORE_PERMIT_BIT] == $past(ctrl_q[STORE_PERMIT_BIT]))
      else $error("direct write reached control");
endmodule : nvm_access_ctrl

// ===== design/nvm_pkg.sv
// Package of constants and types for the data nonvolatile access controller.
package nvm_pkg;
   // Special function register locations as seen by the processor.
   localparam logic [7:0] LOC_REG_ADDR = 8'h3e;
   localparam logic [7:0] BYTE_REG_ADDR = 8'h3f;
   localparam logic [7:0] CTRL_REG_ADDR = 8'h40;
   localparam logic [1:0] CTRL_BANK = 2'h1;
   localparam logic [1:0] DATA_BANK = 2'h0;
   // Control register field positions.
   localparam int FETCH_TRIG_BIT = 0;
   localparam int FETCH_PERMIT_BIT = 1;
   localparam int STORE_TRIG_BIT = 2;
   localparam int STORE_PERMIT_BIT = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_IMPL_MASK = 8'h0f;
   localparam logic [7:0] LOC_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // Cycle timing: a write takes a programming time, a read a few clocks.
   localparam int CLK_PERIOD_NS = 8;
   localparam int STORE_TIME_NS = 40000;
   localparam int STORE_CYCLES = (STORE_TIME_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int FETCH_CYCLES = 2;
   localparam int DEPTH_SMALL = 128;
   localparam int DEPTH_LARGE = 256;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_STORE = 2'b10
   } nvm_state_t;

   // One special function register access from the processor.
   typedef struct packed {
      logic rd;
      logic wr;
      logic indirect;
      logic [1:0] bank;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;
endpackage : nvm_pkg

// ===== tb/test_nvm_access_ctrl.sv
// Self-checking testbench for the nonvolatile access controller.
`timescale 1ns/10ps
module test_nvm_access_ctrl
   import nvm_pkg::*;
;
   logic mclk;
   logic nrst;
   sfr_req_t req;
   logic done_clear;
   logic [7:0] rdata;
   logic done_flag;
   logic busy;
   int n_fail = 0;
   int check_count = 0;
   logic [7:0] q;

   // A short store time keeps the run brief; the small array exercises bit 7.
   localparam int STORE_CYC_SIM = 4;
   nvm_access_ctrl #(.DEPTH(DEPTH_SMALL), .STORE_CYC(STORE_CYC_SIM)) i_dut (
      .mclk(mclk),
      .nrst(nrst),
      .req(req),
      .done_clear(done_clear),
      .rdata(rdata),
      .done_flag(done_flag),
      .busy(busy)
   );

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk

   // One register access; read data is taken one cycle after the request.
   task automatic acc(input logic w, input logic ind, input logic [7:0] a,
                      input logic [7:0] d);
      @(negedge mclk);
      req = '{rd: !w, wr: w, indirect: ind, bank: ind ? CTRL_BANK : DATA_BANK,
              addr: a, wdata: d};
      @(negedge mclk);
      req = '0;
      q = rdata;
   endtask : acc

   task automatic t_reset;
      acc(1'b0, 1'b1, CTRL_REG_ADDR, 8'h00);
      chk("ctrl reset", 8'h00, q);
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'hfa);
      acc(1'b0, 1'b1, CTRL_REG_ADDR, 8'h00);
      chk("ctrl upper bits", 8'h0a, q);
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_refuse;
      acc(1'b1, 1'b0, CTRL_REG_ADDR, 8'h0a);
      acc(1'b0, 1'b1, CTRL_REG_ADDR, 8'h00);
      chk("ctrl direct write", 8'h00, q);
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h04);
      chk("busy no permit", 8'h00, {7'h00, busy});
      acc(1'b1, 1'b0, BYTE_REG_ADDR, 8'h3c);
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h01);
      repeat (4) @(negedge mclk);
      acc(1'b0, 1'b0, BYTE_REG_ADDR, 8'h00);
      chk("byte no fetch", 8'h3c, q);
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_store;
      int n;
      acc(1'b1, 1'b0, LOC_REG_ADDR, 8'h85);
      acc(1'b0, 1'b0, LOC_REG_ADDR, 8'h00);
      chk("loc bit7", 8'h05, q);
      acc(1'b1, 1'b0, BYTE_REG_ADDR, 8'ha5);
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h08);
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h0c);
      chk("busy start", 8'h01, {7'h00, busy});
      acc(1'b1, 1'b0, BYTE_REG_ADDR, 8'h11);
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      chk("busy end", 8'h00, {7'h00, busy});
      // Two of the store cycles pass during the byte write above.
      chk("busy length", 8'(STORE_CYC_SIM - 2), 8'(n));
      chk("done set", 8'h01, {7'h00, done_flag});
      repeat (3) @(negedge mclk);
      chk("done sticky", 8'h01, {7'h00, done_flag});
      done_clear = 1'b1;
      @(negedge mclk);
      done_clear = 1'b0;
      @(negedge mclk);
      chk("done clear", 8'h00, {7'h00, done_flag});
      $display("test store done");
   endtask : t_store

   task automatic t_fetch;
      acc(1'b1, 1'b0, BYTE_REG_ADDR, 8'h00);
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h02);
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h03);
      repeat (4) @(negedge mclk);
      acc(1'b0, 1'b1, CTRL_REG_ADDR, 8'h00);
      chk("fetch trig clear", 8'h02, q);
      acc(1'b0, 1'b0, BYTE_REG_ADDR, 8'h00);
      chk("fetched byte", 8'ha5, q);
      $display("test fetch done");
   endtask : t_fetch

   // A clear held across the end of a store loses to the hardware set.
   task automatic t_race;
      int n;
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h08);
      done_clear = 1'b1;
      acc(1'b1, 1'b1, CTRL_REG_ADDR, 8'h0c);
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      chk("busy length full", 8'(STORE_CYC_SIM), 8'(n));
      chk("done set wins", 8'h01, {7'h00, done_flag});
      @(negedge mclk);
      done_clear = 1'b0;
      chk("done clear after set", 8'h00, {7'h00, done_flag});
      $display("test race done");
   endtask : t_race

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      nrst = 1'b0;
      req = '0;
      done_clear = 1'b0;
      repeat (4) @(negedge mclk);
      nrst = 1'b1;
      t_reset();
      t_refuse();
      t_store();
      t_fetch();
      t_race();
      finish_test();
   end

   // The tests need about seventy cycles; this limit leaves wide margin.
   initial begin
      #20000;
      $display("watchdog expired");
      n_fail++;
      finish_test();
   end
endmodule : test_nvm_access_ctrl
